// ### shared/flash_params.svh
/*
 * Shared constants of the muxed flash host bus: address map, burst
 * configuration layout, status bits and timing counts.
 * Assumes both ends run on a 125 MHz sys_clk.
 */
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH
// What this block does
// - every 128-word boundary and zero is crossing
// - timing bit one: ready with data word
// - timing bit zero: ready one cycle early
// - wait code picks first-data edge, 3rd..13th
// - later words on each following rising edge unless their bank is busy
// - host spaces program suspend 30us after resume
// - host reads status twice before trusting
// - other banks readable while one bank busy
// - chip select low before address strobe low
// - address valid around the address strobe of non-burst cycles
// ----------------------------------------------------------------
// bus layout
// ----------------------------------------------------------------
`define DQ_W 16
`define AHI_W 8
`define CFG_ADDR 24'hff0000
`define CFG_RESET 16'h8900
`define CFG_ASYNC_BIT 15
`define CFG_WS_MSB 14
`define CFG_WS_LSB 11
`define CFG_RDYT_BIT 8
`define WS_MIN 4'h1
`define WS_MAX 4'hb
`define XING_MASK 7'h7f
`define ST_TGL_BIT 6
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SYS_MHZ 125
`define PROG_CYC 200
`define GUARD_US 30
`define GUARD_CYC (`GUARD_US * `SYS_MHZ)
`define ACC_NS 80
`define ACC_CYC ((((`ACC_NS * `SYS_MHZ) + 999) / 1000) + 4)
`define LINK_DIV 4
`define STEP_CYC 4
`endif

// ### shared/flash_pkg.sv
/*
 * Types shared by both ends of the muxed flash bus.
 * Assumes nothing beyond the constants header.
 */
package flash_pkg;
    typedef enum logic [1:0] {
        K_READ  = 2'h0,
        K_WRITE = 2'h1,
        K_POLL  = 2'h2,
        K_BURST = 2'h3
    } kind_e;

    typedef enum logic [11:0] {
        H_IDLE = 12'h001,
        H_CE   = 12'h002,
        H_AVL  = 12'h004,
        H_AVH  = 12'h008,
        H_OE   = 12'h010,
        H_WD   = 12'h020,
        H_WE   = 12'h040,
        H_WU   = 12'h080,
        H_BA   = 12'h100,
        H_BL   = 12'h200,
        H_BR   = 12'h400,
        H_END  = 12'h800
    } host_st_e;
endpackage

// ### shared/flash_bus_if.sv
/*
 * Pins of the muxed address/data flash bus.
 * Assumes the host owns the clock and strobes; the shared data wire
 * is resolved here from the two output enables.
 */
interface flash_bus_if;
    logic        clk;
    logic        ce_n;
    logic        address_valid_strobe_n;
    logic        oe_n;
    logic        we_n;
    logic        rdy;
    logic [7:0]  addr_hi;
    logic [15:0] h_dq_o;
    logic        h_dq_oe;
    logic [15:0] d_dq_o;
    logic        d_dq_oe;
    logic [15:0] dq;

    // bus keeper: an undriven wire reads as zero
    assign dq = h_dq_oe ? h_dq_o : (d_dq_oe ? d_dq_o : 16'h0000);

    modport host (output clk, ce_n, address_valid_strobe_n, oe_n, we_n,
                  addr_hi, h_dq_o, h_dq_oe, input dq, rdy);
    modport dev  (input clk, ce_n, address_valid_strobe_n, oe_n, we_n,
                  addr_hi, dq, output d_dq_o, d_dq_oe, rdy);
endinterface

// ### src/flash_dev.sv
/*
 * Device end of the muxed flash bus: burst configuration, async and
 * burst reads, async programming with one bank busy at a time.
 * Assumes all pins come from the host's domain and are synchronised.
 */
`include "flash_params.svh"

module flash_dev
    import flash_pkg::*;
#(
    parameter int MEM_AW    = 10,
    parameter int BANK_W    = 3,
    parameter int PROG_CYC  = `PROG_CYC,
    parameter int XING_WAIT = 0
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    flash_bus_if.dev               bus,
    output logic [15:0]            burst_configuration,
    output logic                   embedded_busy,
    output logic [BANK_W-1:0]      busy_bank
);
    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    localparam int SW = 5 + `AHI_W + `DQ_W;
    localparam logic [SW-1:0] SYNC_RST = {5'h0f, {(SW-5){1'b0}}};
    localparam logic [3:0] XW = XING_WAIT[3:0];
    localparam int PW = $clog2(PROG_CYC + 1);

    logic [SW-1:0] s1_ff;
    logic [SW-1:0] s2_ff;
    logic [SW-1:0] s3_ff;
    wire  [SW-1:0] raw = {bus.clk, bus.ce_n, bus.address_valid_strobe_n,
                          bus.oe_n, bus.we_n, bus.addr_hi, bus.dq};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_ff <= SYNC_RST;
            s2_ff <= SYNC_RST;
            s3_ff <= SYNC_RST;
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    wire        l_clk     = s2_ff[SW-1];
    wire        sel       = ~s2_ff[SW-2];
    wire        avs_n     = s2_ff[SW-3];
    wire        oe_n      = s2_ff[SW-4];
    wire        we_n      = s2_ff[SW-5];
    wire [23:0] bus_addr  = s2_ff[`DQ_W+`AHI_W-1:0];
    wire [15:0] dq        = s2_ff[`DQ_W-1:0];
    wire        clk_rise  = l_clk & ~s3_ff[SW-1];
    wire        avs_rise  = avs_n & ~s3_ff[SW-3];
    wire        we_rise   = we_n & ~s3_ff[SW-5];
    wire        oe_fall   = ~oe_n & s3_ff[SW-4];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0]       mem [2**MEM_AW];
    logic [15:0]       cfg_ff;
    logic [23:0]       a_ff;
    logic              busy_ff;
    logic [BANK_W-1:0] bank_ff;
    logic [MEM_AW-1:0] pa_ff;
    logic [15:0]       pd_ff;
    logic [PW-1:0]     pcnt_ff;
    logic              tgl_ff;
    logic              bon_ff;
    logic              run_ff;
    logic [3:0]        cnt_ff;
    logic [3:0]        xw_ff;
    logic [MEM_AW-1:0] nw_ff;
    logic              pre_v_ff;
    logic [15:0]       pre_d_ff;
    logic [15:0]       bd_ff;
    logic              rdy_ff;
    logic [15:0]       dq_o_ff;
    logic              dq_oe_ff;

    function automatic logic hit(input logic [MEM_AW-1:0] a);
        hit = busy_ff & (a[MEM_AW-1 -: BANK_W] == bank_ff);
    endfunction

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire       async_mode       = cfg_ff[`CFG_ASYNC_BIT];
    wire       ready_timing_bit = cfg_ff[`CFG_RDYT_BIT];
    wire [3:0] ws_code          = cfg_ff[`CFG_WS_MSB:`CFG_WS_LSB];
    // reserved codes clamp to the nearest legal latency
    wire [3:0] ws_eff = (ws_code < `WS_MIN) ? `WS_MIN :
                        ((ws_code > `WS_MAX) ? `WS_MAX : ws_code);

    wire wr_evt   = we_rise & sel;
    wire is_cfg   = (a_ff == `CFG_ADDR);
    wire prog_go  = wr_evt & ~is_cfg & ~busy_ff;
    wire prog_end = busy_ff & (pcnt_ff == '0);
    wire [MEM_AW-1:0] a_idx = a_ff[MEM_AW-1:0];

    logic [15:0] st_word;
    always_comb begin
        st_word = 16'h0000;
        st_word[`ST_TGL_BIT] = tgl_ff;
    end

    // other banks read array data while one bank is busy
    wire [15:0] rd_async = hit(a_idx) ? st_word : mem[a_idx];

    // the next slot is worked out one edge ahead of its data word so
    // that the early ready can be given without a second path
    wire burst_edge = clk_rise & sel & ~async_mode;
    wire start      = burst_edge & ~avs_n;
    wire step       = burst_edge & avs_n & bon_ff;
    // first word lands on edge ws_eff+2 after the latching edge
    wire slot  = run_ff | (cnt_ff == ws_eff);
    wire xing  = (nw_ff[6:0] & `XING_MASK) == 7'h00;
    wire xhold = slot & xing & (xw_ff < XW);
    wire bhold = slot & ~xhold & hit(nw_ff);
    wire nxt_pre_v = slot & ~xhold & ~bhold;
    // timing bit one pairs ready with data, zero leads by one edge
    wire nxt_rdy = ready_timing_bit ? pre_v_ff : nxt_pre_v;

    // ------------------------------------------------------------
    // configuration and address latch
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_ff <= `CFG_RESET;
        end else if (wr_evt & is_cfg) begin
            cfg_ff <= dq;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            a_ff <= 24'h000000;
        end else if ((avs_rise & sel) | start) begin
            a_ff <= bus_addr;
        end
    end

    // ------------------------------------------------------------
    // embedded program
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy_ff <= 1'b0;
            bank_ff <= '0;
            pa_ff   <= '0;
            pd_ff   <= 16'h0000;
            pcnt_ff <= '0;
        end else if (prog_go) begin
            busy_ff <= 1'b1;
            bank_ff <= a_idx[MEM_AW-1 -: BANK_W];
            pa_ff   <= a_idx;
            pd_ff   <= dq;
            pcnt_ff <= PW'(PROG_CYC - 1);
        end else if (prog_end) begin
            busy_ff <= 1'b0;
        end else if (busy_ff) begin
            pcnt_ff <= pcnt_ff - 1'b1;
        end
    end

    // array has no reset: only programmed words read defined
    always_ff @(posedge sys_clk) begin
        if (prog_end) begin
            mem[pa_ff] <= pd_ff;
        end
    end

    // status toggles once per async-mode output-enable read of the busy bank
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tgl_ff <= 1'b0;
        end else if (oe_fall & sel & async_mode & hit(a_idx)) begin
            tgl_ff <= ~tgl_ff;
        end
    end

    // ------------------------------------------------------------
    // burst engine
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bon_ff   <= 1'b0;
            run_ff   <= 1'b0;
            cnt_ff   <= 4'h0;
            xw_ff    <= 4'h0;
            nw_ff    <= '0;
            pre_v_ff <= 1'b0;
            pre_d_ff <= 16'h0000;
            bd_ff    <= 16'h0000;
        end else if (~sel) begin
            bon_ff   <= 1'b0;
            pre_v_ff <= 1'b0;
        end else if (start) begin
            bon_ff   <= 1'b1;
            run_ff   <= 1'b0;
            cnt_ff   <= 4'h0;
            xw_ff    <= 4'h0;
            nw_ff    <= bus_addr[MEM_AW-1:0];
            pre_v_ff <= 1'b0;
        end else if (step) begin
            // each edge shows the slot prepared on the edge before
            bd_ff    <= pre_d_ff;
            pre_v_ff <= nxt_pre_v;
            run_ff   <= slot;
            if (!run_ff) begin
                cnt_ff <= cnt_ff + 4'h1;
            end
            if (xhold) begin
                xw_ff <= xw_ff + 4'h1;
            end
            if (bhold) begin
                pre_d_ff <= 16'h0000;
            end else if (nxt_pre_v) begin
                pre_d_ff <= mem[nw_ff];
                nw_ff    <= nw_ff + 1'b1;
                xw_ff    <= 4'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdy_ff   <= 1'b0;
            dq_oe_ff <= 1'b0;
            dq_o_ff  <= 16'h0000;
        end else begin
            dq_oe_ff <= sel & ~oe_n & we_n;
            dq_o_ff  <= async_mode ? rd_async : bd_ff;
            if (async_mode | ~sel) begin
                rdy_ff <= sel;
            end else if (start) begin
                rdy_ff <= 1'b0;
            end else if (step) begin
                rdy_ff <= nxt_rdy;
            end
        end
    end

    assign bus.rdy             = rdy_ff;
    assign bus.d_dq_o          = dq_o_ff;
    assign bus.d_dq_oe         = dq_oe_ff;
    assign burst_configuration = cfg_ff;
    assign embedded_busy       = busy_ff;
    assign busy_bank           = bank_ff;
endmodule

// ### src/flash_host.sv
/*
 * Host end of the muxed flash bus: makes the link clock, runs async
 * read, write, double-read poll and burst cycles for one user port.
 * Assumes the device sits on the same interface and sys_clk rate.
 */
`include "flash_params.svh"

module flash_host
    import flash_pkg::*;
#(
    parameter int LINK_DIV = `LINK_DIV,
    parameter int STEP     = `STEP_CYC,
    parameter int ACC      = `ACC_CYC,
    parameter int GUARD    = `GUARD_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    flash_bus_if.host        bus,
    input  wire logic        req_valid,
    input  wire kind_e       req_kind,
    input  wire logic [23:0] req_addr,
    input  wire logic [15:0] req_data,
    input  wire logic [7:0]  req_len,
    input  wire logic        req_suspend,
    input  wire logic        req_resume,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    output logic             rsp_stable,
    output logic             suspend_blocked
);
    host_st_e    st_ff, nxt_st;
    kind_e       k_ff;
    logic [15:0] tmr_ff, div_ff, guard_ff;
    logic [23:0] a_ff;
    logic [15:0] d_ff, first_ff, rd_ff;
    logic [7:0]  n_ff, len_ff;
    logic        lclk_ff, res_ff, poll2_ff, rdyt_ff, rdyp_ff;
    logic        ready_ff, sb_ff, rv_ff, rs_ff;
    logic [16:0] y1_ff, y2_ff;
    logic        ce_n_ff, avs_n_ff, oe_n_ff, we_n_ff, dq_oe_ff;
    logic [15:0] dq_o_ff;

    // ------------------------------------------------------------
    // link clock divider and input synchroniser
    // ------------------------------------------------------------
    wire tick     = div_ff == 16'(LINK_DIV - 1);
    wire rise_evt = tick & ~lclk_ff;
    wire fall_evt = tick & lclk_ff;
    wire rdy_s    = y2_ff[16];
    wire [15:0] dq_s = y2_ff[15:0];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_ff  <= 16'h0000;
            lclk_ff <= 1'b0;
            y1_ff   <= 17'h00000;
            y2_ff   <= 17'h00000;
        end else begin
            div_ff  <= tick ? 16'h0000 : div_ff + 16'h0001;
            lclk_ff <= lclk_ff ^ tick;
            y1_ff   <= {bus.rdy, bus.dq};
            y2_ff   <= y1_ff;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // a suspend is held back while the resume guard runs
    wire take   = req_valid & ready_ff & ~(req_suspend & sb_ff);
    wire tdone  = tmr_ff == 16'h0000;
    wire take_w = rdyt_ff ? rdy_s : rdyp_ff;
    wire last_w = (n_ff + 8'h01) >= len_ff;
    wire is_wr  = k_ff == K_WRITE;

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            H_IDLE: if (take) nxt_st = H_CE;
            H_CE:   if (tdone) nxt_st = (k_ff == K_BURST) ? H_BA : H_AVL;
            H_AVL:  if (tdone) nxt_st = H_AVH;
            H_AVH:  if (tdone) nxt_st = is_wr ? H_WD : H_OE;
            H_OE:   if (tdone) nxt_st = H_END;
            H_WD:   if (tdone) nxt_st = H_WE;
            H_WE:   if (tdone) nxt_st = H_WU;
            H_WU:   if (tdone) nxt_st = H_END;
            H_BA:   if (rise_evt) nxt_st = H_BL;
            H_BL:   if (fall_evt) nxt_st = H_BR;
            H_BR:   if (rise_evt && take_w && last_w) nxt_st = H_END;
            H_END:  if (tdone) nxt_st = (k_ff == K_POLL && !poll2_ff) ? H_OE : H_IDLE;
        endcase
    end

    // chip select goes low a step before the strobe, and the address
    // stays on the bus until the strobe has risen again
    wire ce_on  = |(nxt_st & ~(H_IDLE | H_END));
    wire avs_on = |(nxt_st & (H_AVL | H_BA | H_BL));
    wire oe_on  = |(nxt_st & (H_OE | H_BR));
    wire dq_on  = |(nxt_st & (H_CE | H_AVL | H_AVH | H_WD | H_WE | H_WU | H_BA | H_BL));
    wire dat_on = |(nxt_st & (H_WD | H_WE | H_WU));
    wire burst_w = (st_ff == H_BR) & rise_evt & take_w;
    wire op_done = (st_ff == H_OE) & (nxt_st == H_END);
    wire [15:0] nxt_guard = (st_ff == H_END && nxt_st == H_IDLE && is_wr && res_ff) ? 16'(GUARD) :
                            ((guard_ff != 16'h0000) ? guard_ff - 16'h0001 : 16'h0000);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff  <= H_IDLE;
            tmr_ff <= 16'h0000;
        end else begin
            st_ff  <= nxt_st;
            if (nxt_st != st_ff) begin
                tmr_ff <= (nxt_st == H_OE) ? 16'(ACC - 1) : 16'(STEP - 1);
            end else if (!tdone) begin
                tmr_ff <= tmr_ff - 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            k_ff <= K_READ;
            a_ff <= 24'h000000;
            d_ff <= 16'h0000;
            len_ff <= 8'h00;
            res_ff <= 1'b0;
            rdyt_ff <= 1'(`CFG_RESET >> `CFG_RDYT_BIT);
        end else if (take) begin
            k_ff <= req_kind;
            a_ff <= req_addr;
            d_ff <= req_data;
            len_ff <= req_len;
            res_ff <= req_resume;
            // track the device's ready placement from config writes
            if (req_kind == K_WRITE && req_addr == `CFG_ADDR) begin
                rdyt_ff <= req_data[`CFG_RDYT_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            poll2_ff <= 1'b0;
            first_ff <= 16'h0000;
            n_ff     <= 8'h00;
            rdyp_ff  <= 1'b0;
        end else begin
            if (take) begin
                poll2_ff <= 1'b0;
                n_ff     <= 8'h00;
                rdyp_ff  <= 1'b0;
            end
            if (st_ff == H_END && nxt_st == H_OE) begin
                poll2_ff <= 1'b1;
                first_ff <= rd_ff;
            end
            if (st_ff == H_BR && rise_evt) begin
                rdyp_ff <= rdy_s;
            end
            if (burst_w) begin
                n_ff <= n_ff + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ready_ff <= 1'b0;
            guard_ff <= 16'h0000;
            sb_ff    <= 1'b0;
            rv_ff    <= 1'b0;
            rd_ff    <= 16'h0000;
            rs_ff    <= 1'b0;
            ce_n_ff  <= 1'b1;
            avs_n_ff <= 1'b1;
            oe_n_ff  <= 1'b1;
            we_n_ff  <= 1'b1;
            dq_oe_ff <= 1'b0;
            dq_o_ff  <= 16'h0000;
        end else begin
            ready_ff <= nxt_st == H_IDLE;
            guard_ff <= nxt_guard;
            sb_ff    <= nxt_guard != 16'h0000;
            rv_ff    <= (op_done & (k_ff != K_POLL | poll2_ff)) | burst_w;
            if (op_done | burst_w) begin
                rd_ff <= dq_s;
                rs_ff <= (k_ff != K_POLL) | (first_ff == dq_s);
            end
            ce_n_ff  <= ~ce_on;
            avs_n_ff <= ~avs_on;
            oe_n_ff  <= ~oe_on;
            we_n_ff  <= nxt_st != H_WE;
            dq_oe_ff <= dq_on;
            dq_o_ff  <= dat_on ? d_ff : a_ff[15:0];
        end
    end

    assign bus.clk                    = lclk_ff;
    assign bus.ce_n                   = ce_n_ff;
    assign bus.address_valid_strobe_n = avs_n_ff;
    assign bus.oe_n                   = oe_n_ff;
    assign bus.we_n                   = we_n_ff;
    assign bus.addr_hi                = a_ff[23:16];
    assign bus.h_dq_o                 = dq_o_ff;
    assign bus.h_dq_oe                = dq_oe_ff;
    assign req_ready                  = ready_ff;
    assign rsp_valid                  = rv_ff;
    assign rsp_data                   = rd_ff;
    assign rsp_stable                 = rs_ff;
    assign suspend_blocked            = sb_ff;
endmodule

// ### verif/flash_bus_props.sv
/* pin-level checks on the muxed flash bus.
   assumes sys_clk and rst of the bench and the flash_bus_if signals. */
module flash_bus_props (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        ce_n,
    input wire logic        address_valid_strobe_n,
    input wire logic        oe_n,
    input wire logic        we_n,
    input wire logic [7:0]  addr_hi,
    input wire logic [15:0] h_dq_o,
    input wire logic        h_dq_oe,
    input wire logic        d_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // strobe order and bus ownership
    // ----------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_cs_leads_strobe: assert property ($fell(address_valid_strobe_n) |-> !$past(ce_n))
        else $error("strobe fell without chip select");
    a_strobe_in_select: assert property (!address_valid_strobe_n |-> !ce_n && h_dq_oe)
        else $error("strobe low without address driven");
    a_addr_held_low: assert property (!address_valid_strobe_n && !$past(address_valid_strobe_n)
        |-> $stable(h_dq_o) && $stable(addr_hi)) else $error("address moved under strobe");
    a_strobe_released: assert property ($fell(address_valid_strobe_n) |-> ##[1:24] address_valid_strobe_n)
        else $error("strobe stuck low");
    a_single_driver: assert property (h_dq_oe |-> !d_dq_oe)
        else $error("both ends drive the bus");
    a_read_answered: assert property ($fell(oe_n) |-> ##[1:12] d_dq_oe)
        else $error("device did not drive a read");
    a_write_in_select: assert property (!we_n |-> !ce_n && oe_n && address_valid_strobe_n)
        else $error("write strobe outside its cycle");
    a_write_data_held: assert property ($rose(we_n) |-> $past(h_dq_oe) && !ce_n)
        else $error("write data or select dropped early");
endmodule

// ### verif/muxed_flash_host_bus_protocol_tb.sv
/* self-checking bench: flash_host and flash_dev joined by flash_bus_if.
   assumes the shared folder is on the include path; host makes link clock. */
module muxed_flash_host_bus_protocol_tb
    import flash_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        req_valid = 1'b0;
    kind_e       req_kind = K_READ;
    logic [23:0] req_addr = 24'h000000;
    logic [15:0] req_data = 16'h0000;
    logic [7:0]  req_len = 8'h01;
    logic        req_suspend = 1'b0;
    logic        req_resume = 1'b0;
    logic        req_ready, rsp_valid, rsp_stable, suspend_blocked, embedded_busy, clk_q;
    logic [15:0] rsp_data, burst_configuration, cfg;
    logic [2:0]  busy_bank;
    logic [31:0] seed = 32'h00000052;
    logic [15:0] mem [0:1023];
    logic [15:0] got [$];
    int          stamp [$];
    int          miscompares, checks_done, cyc, latch_cyc, took, base;
    flash_bus_if bus ();
    flash_host #(.GUARD(50)) flash_host_inst (.sys_clk(sys_clk), .rst(rst), .bus(bus), .req_valid(req_valid),
        .req_kind(req_kind), .req_addr(req_addr), .req_data(req_data), .req_len(req_len),
        .req_suspend(req_suspend), .req_resume(req_resume), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_stable(rsp_stable), .suspend_blocked(suspend_blocked));
    flash_dev #(.PROG_CYC(120)) flash_dev_inst (.sys_clk(sys_clk), .rst(rst), .bus(bus),
        .burst_configuration(burst_configuration), .embedded_busy(embedded_busy), .busy_bank(busy_bank));
    flash_bus_props flash_bus_props_inst (.sys_clk(sys_clk), .rst(rst), .ce_n(bus.ce_n),
        .address_valid_strobe_n(bus.address_valid_strobe_n), .oe_n(bus.oe_n), .we_n(bus.we_n),
        .addr_hi(bus.addr_hi), .h_dq_o(bus.h_dq_o), .h_dq_oe(bus.h_dq_oe), .d_dq_oe(bus.d_dq_oe));
    // ----------------------------------------------------------------
    // clock, cycle count, address latch edge
    // ----------------------------------------------------------------
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        clk_q <= bus.clk;
        if (bus.clk && !clk_q && !bus.address_valid_strobe_n) latch_cyc <= cyc;
    end
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    // reserved codes clamp to nearest legal
    function automatic int eff(input logic [3:0] w);
        return (w == 4'h0) ? 1 : ((w > 4'hb) ? 11 : int'(w));
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // t is {suspend, resume}
    task automatic issue(input kind_e k, input logic [23:0] a, input logic [15:0] d, input logic [7:0] n,
                         input logic [1:0] t);
        got.delete();
        stamp.delete();
        req_kind = k;
        {req_addr, req_data, req_len, req_suspend, req_resume} = {a, d, n, t};
        req_valid = 1'b1;
        forever begin
            @(posedge sys_clk);
            if (req_ready === 1'b1 && !(t[1] && suspend_blocked === 1'b1)) break;
        end
        took = cyc;
        #1 req_valid = 1'b0;
        while (req_ready !== 1'b1) begin
            @(posedge sys_clk);
            if (rsp_valid === 1'b1) begin
                got.push_back(rsp_data);
                stamp.push_back(cyc);
            end
        end
        #1;
    endtask
    task automatic prog(input logic [23:0] a, input logic [1:0] t);
        mem[a[9:0]] = rnd();
        issue(K_WRITE, a, mem[a[9:0]], 8'h01, t);
    endtask
    initial begin
        #300000;
        miscompares++;
        final_report();
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        logic [9:0] w;
        idle(2);
        rst = 1'b0;
        idle(4);
        check("cfg reset", 16'h8900, burst_configuration);
        for (int i = 0; i < 8; i++) begin
            w = (i < 4) ? 10'(i) : 10'(i + 122);
            prog({14'h0, w}, 2'h0);
            idle(130);
            issue(K_READ, {14'h0, w}, 16'h0000, 8'h01, 2'h0);
            check("async read", mem[w], got[0]);
        end
        prog(24'h000084, 2'h0);
        check("busy bank", 16'h0009, 16'({embedded_busy, busy_bank}));
        issue(K_POLL, 24'h000084, 16'h0000, 8'h01, 2'h0);
        check("poll busy stable", 16'h0000, 16'(rsp_stable));
        issue(K_READ, 24'h00007e, 16'h0000, 8'h01, 2'h0);
        check("other bank read", mem[10'h07e], got[0]);
        idle(130);
        issue(K_POLL, 24'h000084, 16'h0000, 8'h01, 2'h0);
        check("poll done", mem[10'h084], got[0]);
        check("poll done stable", 16'h0001, 16'(rsp_stable));
        for (int i = 1; i <= 16; i++) begin
            cfg = {1'b0, 4'(i), 2'h0, i[0], 8'h00};
            issue(K_WRITE, 24'hff0000, cfg, 8'h01, 2'h0);
            idle(8);
            check("cfg", cfg, burst_configuration);
            w = i[1] ? 10'h07e : 10'h000;
            issue(K_BURST, {14'h0, w}, 16'h0000, 8'h04, 2'h0);
            for (int j = 0; j < 4; j++) check("burst word", mem[w + 10'(j)], got[j]);
            for (int j = 1; j < 4; j++) check("burst gap", 16'h0008, 16'(stamp[j] - stamp[j - 1]));
            if (i == 1) base = stamp[0] - latch_cyc;
            check("latency", 16'(base + 8 * (eff(4'(i)) - 1)), 16'(stamp[0] - latch_cyc));
        end
        prog(24'h000080, 2'h0);
        issue(K_BURST, 24'h00007e, 16'h0000, 8'h04, 2'h0);
        for (int j = 0; j < 4; j++) check("busy crossing", mem[10'h07e + 10'(j)], got[j]);
        idle(130);
        prog(24'h000085, 2'h1);
        base = cyc;
        check("guard on", 16'h0001, 16'(suspend_blocked));
        prog(24'h000086, 2'h2);
        check("guard held", 16'h0001, 16'(took - base > 40));
        final_report();
    end
endmodule
